//--- hdl/frp_read_params.sv
// Read-parameter register pair with pin role, dummy and wrap decode
// Function
// R1 - Persistent and volatile eight-bit parameter copies
// R2 - Power-up copies persistent into volatile
// R3 - Bit 7 picks pause or restart pin
// R4 - Pin bit 0 pause, 1 restart
// R5 - Quad or four-line mode makes data line
// R6 - Dedicated restart enabled forces pause function
// R7 - 65h persistent, C0h/63h volatile, targeted only
// R8 - Bits 6:3 dummy count, zero means default
// R9 - Bits 1:0 burst 8/16/32/64 bytes
// R10 - Bit 2 wraps in burst, else array
// R11 - Host respects clock limit per dummy
// R12 - Defaults 8, 6, 4 by read type
// R13 - ID/discovery/info reads follow fast read
// R14 - Disable bit moves restart to shared pin
// R15 - Operation uses volatile copy
// R16 - Persistent write leaves volatile until reload
`include "frp_cfg.svh"
module frp_read_params
  import frp_pkg::*;
#(
  parameter int ADDR_W = 23
)(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              power_up_req,
  input  wire logic              sclk_pin,
  input  wire logic              cs_n_pin,
  input  wire logic [3:0]        io_pin,
  input  wire logic              quad_enable,
  input  wire logic              four_line_command_mode,
  input  wire logic              dedicated_pin_part,
  input  wire logic              dedicated_pin_disable,
  input  frp_read_kind_e         read_kind,
  input  wire logic [ADDR_W-1:0] cur_addr,
  output frp_params_s            persist_params,
  output frp_params_s            volatile_params,
  output frp_role_e              shared_pin_role,
  output logic                   dedicated_restart_active,
  output logic [3:0]             dummy_cycles,
  output logic [6:0]             burst_bytes,
  output logic                   wrap_active,
  output logic [ADDR_W-1:0]      next_addr,
  output logic                   load_busy
);

  typedef struct packed {
    frp_state_e        st;
    logic              to_nv;
    logic              pend_ok;
    frp_params_s       pend;
    frp_params_s       nv;
    frp_params_s       vol;
    frp_role_e         role;
    logic              ded_active;
    logic [3:0]        dummy;
    logic [6:0]        burst;
    logic              wrap;
    logic [ADDR_W-1:0] naddr;
  } frp_state_s;

  frp_state_s q, d;
  frp_rx_s    rx;
  logic       commit_nv;
  logic       commit_vol;
  logic       single_no_quad;

  frp_link_rx u_rx (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .sclk_pin  (sclk_pin),
    .cs_n_pin  (cs_n_pin),
    .io_pin    (io_pin),
    .four_line (four_line_command_mode),
    .rx        (rx)
  );

  function automatic logic [3:0] dummy_for(
    input frp_read_kind_e kind,
    input logic [3:0]     field,
    input logic           four_line
  );
    logic [3:0] dflt;
    dflt = `FRP_DUMMY_WIDE;
    case (kind)
      FRP_RD_DUAL_IO: dflt = `FRP_DUMMY_DUAL_IO; // R12
      FRP_RD_QUAD_IO: dflt = `FRP_DUMMY_FOUR; // R12
      FRP_RD_FAST, FRP_RD_UNIQUE_ID, FRP_RD_DISC_PARAM, FRP_RD_INFO_ROW: begin
        // Side reads share the fast read setting
        dflt = four_line ? `FRP_DUMMY_FOUR : `FRP_DUMMY_WIDE; // R13
      end
      default: dflt = `FRP_DUMMY_WIDE; // R12
    endcase
    dummy_for = (field != 4'h0) ? field : dflt; // R8
  endfunction : dummy_for

  function automatic logic [6:0] burst_of(input logic [1:0] sel);
    burst_of = 7'(`FRP_BURST_MIN << sel); // R9
  endfunction : burst_of

  function automatic logic [ADDR_W-1:0] advance(
    input logic [ADDR_W-1:0] addr,
    input logic              wrap_en,
    input logic [6:0]        bytes
  );
    logic [ADDR_W-1:0] inc;
    logic [ADDR_W-1:0] mask;
    inc = ADDR_W'(addr + 1'b1);
    mask = ADDR_W'(bytes - 7'h01);
    // Plain increment rolls over at the array end
    if (wrap_en) begin
      advance = (addr & ~mask) | (inc & mask); // R10
    end else begin
      advance = inc; // R10
    end
  endfunction : advance

  assign single_no_quad = !quad_enable && !four_line_command_mode;
  assign commit_nv  = rx.frame_end && q.pend_ok && q.to_nv;
  assign commit_vol = rx.frame_end && q.pend_ok && !q.to_nv;

  always_comb begin
    d = q;
    case (q.st)
      FRP_ST_LOAD: begin
        d.vol = q.nv; // R2
        d.st = FRP_ST_IDLE;
      end
      FRP_ST_IDLE: begin
        if (rx.vld && rx.is_cmd) begin
          d.st = FRP_ST_SKIP;
          if (rx.data == `FRP_CMD_SET_PERSIST) begin
            d.to_nv = 1'b1; // R7
            d.st = FRP_ST_DATA;
          end else if (rx.data == `FRP_CMD_SET_VOL_A ||
                       rx.data == `FRP_CMD_SET_VOL_B) begin
            d.to_nv = 1'b0; // R7
            d.st = FRP_ST_DATA;
          end
        end
      end
      FRP_ST_DATA: begin
        if (rx.vld) begin
          d.pend = frp_params_s'(rx.data);
          d.pend_ok = 1'b1;
          d.st = FRP_ST_SKIP;
        end else if (rx.frame_end) begin
          d.st = FRP_ST_IDLE;
        end
      end
      FRP_ST_SKIP: begin
        // Extra bytes after the data byte are ignored
        if (rx.frame_end) begin
          d.st = FRP_ST_IDLE;
          d.pend_ok = 1'b0;
        end
      end
      default: d.st = FRP_ST_IDLE;
    endcase
    // Only the targeted copy changes; a short frame writes nothing
    if (commit_nv) begin
      d.nv = q.pend; // R7 R16
    end
    if (commit_vol) begin
      d.vol = q.pend; // R7
    end
    if (rx.frame_end && q.st != FRP_ST_LOAD && q.st != FRP_ST_SKIP) begin
      d.st = FRP_ST_IDLE;
      d.pend_ok = 1'b0;
    end
    if (power_up_req) begin
      d.st = FRP_ST_LOAD; // R2
      d.pend_ok = 1'b0;
    end
    d.ded_active = dedicated_pin_part && !dedicated_pin_disable; // R14
    if (!single_no_quad) begin
      d.role = FRP_ROLE_DATA; // R5
    end else if (dedicated_pin_part && !dedicated_pin_disable) begin
      d.role = FRP_ROLE_PAUSE; // R6
    end else if (q.vol.pin_function_select) begin
      d.role = FRP_ROLE_RESTART; // R3 R4 R14 R15
    end else begin
      d.role = FRP_ROLE_PAUSE; // R3 R4
    end
    d.dummy = dummy_for(read_kind, q.vol.dummy, four_line_command_mode); // R15
    d.burst = burst_of({q.vol.burst_size_high, q.vol.burst_size_low}); // R15
    d.wrap = q.vol.wrap_boundary_enable; // R15
    d.naddr = advance(cur_addr, q.vol.wrap_boundary_enable,
                      burst_of({q.vol.burst_size_high, q.vol.burst_size_low}));
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q.st <= FRP_ST_LOAD;
      q.to_nv <= 1'b0;
      q.pend_ok <= 1'b0;
      q.pend <= frp_params_s'(`FRP_RESET_VAL);
      q.nv <= frp_params_s'(`FRP_RESET_VAL); // R1
      q.vol <= frp_params_s'(`FRP_RESET_VAL); // R1
      q.role <= FRP_ROLE_PAUSE;
      q.ded_active <= 1'b0;
      q.dummy <= `FRP_DUMMY_WIDE;
      q.burst <= `FRP_BURST_MIN;
      q.wrap <= 1'b0;
      q.naddr <= '0;
    end else begin
      q <= d;
    end
  end

  assign persist_params = q.nv;
  assign volatile_params = q.vol;
  assign shared_pin_role = q.role;
  assign dedicated_restart_active = q.ded_active;
  assign dummy_cycles = q.dummy;
  assign burst_bytes = q.burst;
  assign wrap_active = q.wrap;
  assign next_addr = q.naddr;
  assign load_busy = (q.st == FRP_ST_LOAD);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_data_taken;
    q.st == FRP_ST_DATA && rx.vld;
  endsequence

  sequence s_frame_closed;
    rx.frame_end && q.pend_ok;
  endsequence

  property p_power_load;
    q.st == FRP_ST_LOAD && !power_up_req |=> q.vol == $past(q.nv)
      && q.st == FRP_ST_IDLE;
  endproperty
  a_power_load: assert property (p_power_load) // R2
    else $error("volatile copy not reloaded at power-up");

  property p_persist_only;
    commit_nv && !power_up_req |=> q.nv == $past(q.pend) && $stable(q.vol);
  endproperty
  a_persist_only: assert property (p_persist_only) // R16
    else $error("persistent write disturbed volatile copy");

  property p_volatile_only;
    s_frame_closed ##0 !q.to_nv |=> q.vol == $past(q.pend) && $stable(q.nv);
  endproperty
  a_volatile_only: assert property (p_volatile_only) // R7
    else $error("volatile write disturbed persistent copy");

  property p_data_pending;
    s_data_taken |=> q.pend_ok && q.pend == $past(rx.data);
  endproperty
  a_data_pending: assert property (p_data_pending) // R7
    else $error("data byte not captured");

  property p_data_line;
    !single_no_quad |=> q.role == FRP_ROLE_DATA;
  endproperty
  a_data_line: assert property (p_data_line) // R5
    else $error("shared pin not data line in quad mode");

  property p_dedicated_pause;
    single_no_quad && dedicated_pin_part && !dedicated_pin_disable
      |=> q.role == FRP_ROLE_PAUSE;
  endproperty
  a_dedicated_pause: assert property (p_dedicated_pause) // R6
    else $error("pause not forced with dedicated restart pin");

  property p_pin_bit;
    single_no_quad && (!dedicated_pin_part || dedicated_pin_disable)
      |=> q.role == ($past(q.vol.pin_function_select) ?
                     FRP_ROLE_RESTART : FRP_ROLE_PAUSE);
  endproperty
  a_pin_bit: assert property (p_pin_bit) // R3
    else $error("pin function bit not honoured");

  property p_dummy_field;
    q.vol.dummy != 4'h0 |=> q.dummy == $past(q.vol.dummy);
  endproperty
  a_dummy_field: assert property (p_dummy_field) // R8
    else $error("dummy count differs from field");

  property p_dummy_dual_io;
    q.vol.dummy == 4'h0 && read_kind == FRP_RD_DUAL_IO
      |=> q.dummy == `FRP_DUMMY_DUAL_IO;
  endproperty
  a_dummy_dual_io: assert property (p_dummy_dual_io) // R12
    else $error("dual I/O default dummy wrong");

  property p_burst;
    1'b1 |=> q.burst == 7'(`FRP_BURST_MIN <<
      $past({q.vol.burst_size_high, q.vol.burst_size_low}));
  endproperty
  a_burst: assert property (p_burst) // R9
    else $error("burst length decode wrong");

  property p_no_wrap;
    !q.vol.wrap_boundary_enable |=> q.naddr == ADDR_W'($past(cur_addr) + 1'b1);
  endproperty
  a_no_wrap: assert property (p_no_wrap) // R10
    else $error("address wrapped with wrap disabled");

endmodule : frp_read_params

//--- inc/frp_cfg.svh
// Constants of the flash read-parameter register block
`ifndef FRP_CFG_SVH
`define FRP_CFG_SVH

`define FRP_CMD_SET_PERSIST 8'h65
`define FRP_CMD_SET_VOL_A   8'hc0
`define FRP_CMD_SET_VOL_B   8'h63

`define FRP_RESET_VAL       8'h00
`define FRP_BIT_PIN_FUNC    7
`define FRP_BIT_DUMMY_HI    6
`define FRP_BIT_DUMMY_LO    3
`define FRP_BIT_WRAP        2
`define FRP_BIT_BURST_HI    1
`define FRP_BIT_BURST_LO    0

`define FRP_DUMMY_WIDE      4'h8
`define FRP_DUMMY_FOUR      4'h6
`define FRP_DUMMY_DUAL_IO   4'h4

`define FRP_BURST_MIN       7'h08
`define FRP_BITS_SINGLE     4'h1
`define FRP_BITS_FOUR       4'h4
`define FRP_BITS_BYTE       4'h8

`endif

//--- inc/frp_pkg.sv
// Types shared by the read-parameter register block
package frp_pkg;

  typedef struct packed {
    logic       pin_function_select;
    logic [3:0] dummy;
    logic       wrap_boundary_enable;
    logic       burst_size_high;
    logic       burst_size_low;
  } frp_params_s;

  typedef enum logic [1:0] {
    FRP_ROLE_PAUSE   = 2'b00,
    FRP_ROLE_RESTART = 2'b01,
    FRP_ROLE_DATA    = 2'b10
  } frp_role_e;

  typedef enum logic [3:0] {
    FRP_RD_FAST          = 4'b0000,
    FRP_RD_DUAL_OUT      = 4'b0001,
    FRP_RD_DUAL_IO       = 4'b0010,
    FRP_RD_QUAD_OUT      = 4'b0011,
    FRP_RD_QUAD_IO       = 4'b0100,
    FRP_RD_UNIQUE_ID     = 4'b0101,
    FRP_RD_DISC_PARAM    = 4'b0110,
    FRP_RD_INFO_ROW      = 4'b0111
  } frp_read_kind_e;

  typedef enum logic [1:0] {
    FRP_ST_LOAD = 2'b00,
    FRP_ST_IDLE = 2'b01,
    FRP_ST_DATA = 2'b10,
    FRP_ST_SKIP = 2'b11
  } frp_state_e;

  typedef struct packed {
    logic       vld;
    logic       is_cmd;
    logic [7:0] data;
    logic       frame_end;
  } frp_rx_s;

endpackage : frp_pkg

//--- hdl/frp_link_rx.sv
// Serial link receiver: pin synchronisers and byte assembly
`include "frp_cfg.svh"
module frp_link_rx
  import frp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       sclk_pin,
  input  wire logic       cs_n_pin,
  input  wire logic [3:0] io_pin,
  input  wire logic       four_line,
  output frp_rx_s         rx
);

  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [3:0] io_a;
    logic [3:0] io_b;
    logic       sclk_last;
    logic       in_frame;
    logic       first;
    logic [3:0] cnt;
    logic [7:0] sh;
    frp_rx_s    out;
  } frp_rx_state_s;

  frp_rx_state_s q, d;
  logic [3:0]    step;
  logic [7:0]    sh_n;

  always_comb begin
    d = q;
    step = four_line ? `FRP_BITS_FOUR : `FRP_BITS_SINGLE;
    sh_n = four_line ? {q.sh[3:0], q.io_b} : {q.sh[6:0], q.io_b[0]};
    // First stages feed only the second stages
    d.sclk_s = {q.sclk_s[0], sclk_pin};
    d.cs_s   = {q.cs_s[0], cs_n_pin};
    d.io_a   = io_pin;
    d.io_b   = q.io_a;
    d.sclk_last = q.sclk_s[1];
    d.out.vld = 1'b0;
    d.out.frame_end = 1'b0;
    if (q.cs_s[1]) begin
      // Deselect ends the frame and drops any partial byte
      d.out.frame_end = q.in_frame;
      d.in_frame = 1'b0;
      d.first = 1'b1;
      d.cnt = 4'h0;
    end else begin
      d.in_frame = 1'b1;
      if (q.sclk_s[1] && !q.sclk_last) begin
        d.sh = sh_n;
        if (q.cnt + step == `FRP_BITS_BYTE) begin
          d.cnt = 4'h0;
          d.first = 1'b0;
          d.out.vld = 1'b1;
          d.out.is_cmd = q.first;
          d.out.data = sh_n;
        end else begin
          d.cnt = 4'(q.cnt + step);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '{sclk_s: 2'h0, cs_s: 2'h3, io_a: 4'h0, io_b: 4'h0,
             sclk_last: 1'b0, in_frame: 1'b0, first: 1'b1,
             cnt: 4'h0, sh: 8'h00, out: '0};
    end else begin
      q <= d;
    end
  end

  assign rx = q.out;

endmodule : frp_link_rx

//--- tb/frp_host_model.sv
// Host-side serial frame driver for the read-parameter register
module frp_host_model (
  input  wire logic       ref_clk,
  output logic            sclk_pin,
  output logic            cs_n_pin,
  output logic [3:0]      io_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk_pin = 1'b0;
    cs_n_pin = 1'b1;
    io_pin   = 4'h0;
  end

  // Sends the first n bits MSB first, a nibble per edge in four-line mode
  task automatic send(input logic [15:0] bits, input int n, input logic quad);
    @(negedge ref_clk);
    cs_n_pin = 1'b0;
    for (int i = 15; i > 15 - n; i = quad ? i - 4 : i - 1) begin
      io_pin    = quad ? bits[i -: 4] : {3'h0, bits[i]};
      repeat (4) @(negedge ref_clk);
      // Link period of 32 ns stays far under any read clock limit
      sclk_pin = 1'b1;
      repeat (4) @(negedge ref_clk);
      sclk_pin = 1'b0;
    end
    repeat (4) @(negedge ref_clk);
    cs_n_pin = 1'b1;
    // Released line must not keep the last bit
    io_pin   = ~io_pin;
    repeat (6) @(negedge ref_clk);
  endtask : send
endmodule : frp_host_model

//--- tb/tb_top.sv
// Self-checking bench for the read-parameter register pair
`include "frp_cfg.svh"
module tb_top
  import frp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic           ref_clk;
  logic           rst_n;
  logic           power_up_req;
  logic           sclk_pin;
  logic           cs_n_pin;
  logic [3:0]     io_pin;
  logic           quad_enable;
  logic           four_line_command_mode;
  logic           dedicated_pin_part;
  logic           dedicated_pin_disable;
  frp_read_kind_e read_kind;
  logic [22:0]    cur_addr;
  frp_params_s    persist_params;
  frp_params_s    volatile_params;
  frp_role_e      shared_pin_role;
  logic           dedicated_restart_active;
  logic [3:0]     dummy_cycles;
  logic [6:0]     burst_bytes;
  logic           wrap_active;
  logic [22:0]    next_addr;
  logic           load_busy;
  logic [7:0]     m_pers;
  logic [7:0]     m_vol;
  integer         seed;
  int             fail_count;
  int             num_checks;
  int             cycles;
  int             fl_kinds [5] = '{0, 4, 5, 6, 7};

  frp_host_model frp_host_model_inst (
    .ref_clk  (ref_clk),
    .sclk_pin (sclk_pin),
    .cs_n_pin (cs_n_pin),
    .io_pin   (io_pin)
  );

  frp_read_params frp_read_params_inst (
    .ref_clk                  (ref_clk),
    .rst_n                    (rst_n),
    .power_up_req             (power_up_req),
    .sclk_pin                 (sclk_pin),
    .cs_n_pin                 (cs_n_pin),
    .io_pin                   (io_pin),
    .quad_enable              (quad_enable),
    .four_line_command_mode   (four_line_command_mode),
    .dedicated_pin_part       (dedicated_pin_part),
    .dedicated_pin_disable    (dedicated_pin_disable),
    .read_kind                (read_kind),
    .cur_addr                 (cur_addr),
    .persist_params           (persist_params),
    .volatile_params          (volatile_params),
    .shared_pin_role          (shared_pin_role),
    .dedicated_restart_active (dedicated_restart_active),
    .dummy_cycles             (dummy_cycles),
    .burst_bytes              (burst_bytes),
    .wrap_active              (wrap_active),
    .next_addr                (next_addr),
    .load_busy                (load_busy)
  );

  always #2 ref_clk = ~ref_clk;

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("[FAIL] timeout expected finish seen hang");
      give_verdict();
    end
  end

  task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_dec(input string what, input logic [22:0] exp, input logic [22:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_dec

  // Model follows only whole frames with a known command
  task automatic frame(input logic [7:0] cmd, input logic [7:0] val, input int n);
    frp_host_model_inst.send({cmd, val}, n, four_line_command_mode);
    if (n == 16 && cmd == `FRP_CMD_SET_PERSIST) m_pers = val;
    if (n == 16 && (cmd == `FRP_CMD_SET_VOL_A || cmd == `FRP_CMD_SET_VOL_B)) m_vol = val;
    repeat (2) @(negedge ref_clk);
    chk_reg("persist", m_pers, persist_params);
    chk_reg("volatile", m_vol, volatile_params);
  endtask : frame

  task automatic chk_decode(input int k, input logic fl);
    logic [3:0]  d;
    logic [6:0]  b;
    logic [22:0] a;
    frp_role_e   r;
    logic        qe;
    logic        pp;
    logic        pd;
    qe = 1'($random(seed));
    pp = 1'($random(seed));
    pd = 1'($random(seed));
    read_kind = frp_read_kind_e'(k[3:0]);
    four_line_command_mode = fl;
    quad_enable = qe & 1'($random(seed));
    dedicated_pin_part = pp;
    dedicated_pin_disable = pd;
    // Some addresses sit on the last byte of every burst block
    cur_addr = 23'($random(seed)) | ((k == 3) ? 23'h3f : 23'h0);
    repeat (2) @(negedge ref_clk);
    d = m_vol[6:3];
    if (d == 4'h0) d = (fl || k == 4) ? 4'h6 : (k == 2) ? 4'h4 : 4'h8;
    b = 7'h08 << m_vol[1:0];
    a = cur_addr + 23'h1;
    if (m_vol[2]) a = cur_addr - (cur_addr % 23'(b)) + (a % 23'(b));
    r = (quad_enable || fl) ? FRP_ROLE_DATA : (pp && !pd) ? FRP_ROLE_PAUSE :
        m_vol[7] ? FRP_ROLE_RESTART : FRP_ROLE_PAUSE;
    chk_dec("dummy", 23'(d), 23'(dummy_cycles));
    chk_dec("burst", 23'(b), 23'(burst_bytes));
    chk_dec("wrap", 23'(m_vol[2]), 23'(wrap_active));
    chk_dec("next_addr", a, next_addr);
    chk_dec("role", 23'(r), 23'(shared_pin_role));
    chk_dec("ded_restart", 23'(pp && !pd), 23'(dedicated_restart_active));
  endtask : chk_decode

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    power_up_req = 1'b0;
    quad_enable = 1'b0;
    four_line_command_mode = 1'b0;
    dedicated_pin_part = 1'b0;
    dedicated_pin_disable = 1'b0;
    read_kind = FRP_RD_FAST;
    cur_addr = 23'h0;
    seed = 27970;
    m_pers = `FRP_RESET_VAL;
    m_vol = `FRP_RESET_VAL;
    repeat (2) @(negedge ref_clk);
    chk_dec("load_busy", 23'h1, 23'(load_busy));
    rst_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk_dec("load_busy", 23'h0, 23'(load_busy));
    chk_reg("persist", m_pers, persist_params);
    chk_reg("volatile", m_vol, volatile_params);
    $display("Test reset done");
    frame(`FRP_CMD_SET_VOL_A, 8'($random(seed)), 16);
    frame(`FRP_CMD_SET_VOL_B, 8'($random(seed)), 16);
    $display("Test volatile write done");
    frame(`FRP_CMD_SET_PERSIST, 8'($random(seed)), 16);
    $display("Test persistent write done");
    frame(8'h66, 8'($random(seed)), 16);
    frame(`FRP_CMD_SET_VOL_A, 8'($random(seed)), 12);
    $display("Test refused frames done");
    four_line_command_mode = 1'b1;
    frame(`FRP_CMD_SET_VOL_B, 8'($random(seed)), 16);
    frame(`FRP_CMD_SET_PERSIST, 8'($random(seed)), 12);
    four_line_command_mode = 1'b0;
    $display("Test four-line frames done");
    power_up_req = 1'b1;
    @(negedge ref_clk);
    power_up_req = 1'b0;
    m_vol = m_pers;
    repeat (3) @(negedge ref_clk);
    chk_reg("volatile", m_vol, volatile_params);
    $display("Test reload done");
    for (int i = 0; i < 12; i++) begin
      frame(`FRP_CMD_SET_VOL_B, (i == 0) ? 8'h00 : (i == 1) ? 8'h87 : (i == 2) ? 8'hff :
            8'($random(seed)), 16);
      for (int k = 0; k < 8; k++) chk_decode(k, 1'b0);
      for (int j = 0; j < 5; j++) chk_decode(fl_kinds[j], 1'b1);
      four_line_command_mode = 1'b0;
      quad_enable = 1'b0;
    end
    $display("Test decode done");
    give_verdict();
  end
endmodule : tb_top
